/* bench/pmc_power_mode_controller_props.sv */
// port assertions for the power mode controller
`timescale 1ns/100ps
`default_nettype none
module pmc_power_mode_controller_props #(
  parameter PIN_W = 8
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             rst,
  // wake inputs
  input wire logic             irqAny,
  input wire logic             resetPin_n,
  // observed outputs
  input wire logic [PIN_W-1:0] padOut,
  input wire logic             cpuClkEn,
  input wire logic             memClkEn,
  input wire logic             fastClkOn,
  input wire logic             slowClkOn,
  input wire logic             aonPowered,
  input wire logic             corePowered,
  input wire logic [1:0]       retentionLevel,
  input wire logic             watchdogRun,
  input wire logic             sysReset,
  input wire logic [2:0]       modeState
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_run; modeState == 3'h0 |-> cpuClkEn && memClkEn; endproperty
  a_run: assert property (p_run) else $error("cpu clock gated in active");
  property p_idle; modeState == 3'h1 |-> !cpuClkEn && !memClkEn && corePowered; endproperty
  a_idle: assert property (p_idle) else $error("cpu clock running in idle");
  property p_wake; modeState == 3'h1 && irqAny |-> ##[1:6] modeState == 3'h0; endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not end idle");
  property p_fast; fastClkOn == (modeState < 3'h2); endproperty
  a_fast: assert property (p_fast) else $error("fast clock in wrong mode");
  property p_slow; slowClkOn == (modeState < 3'h3); endproperty
  a_slow: assert property (p_slow) else $error("slow clock in wrong mode");
  property p_stby; modeState == 3'h2 |-> retentionLevel == 2'h1 && aonPowered && !corePowered; endproperty
  a_stby: assert property (p_stby) else $error("standby power state wrong");
  property p_hold; modeState == 3'h2 && $past(modeState) == 3'h2 |-> $stable(padOut); endproperty
  a_hold: assert property (p_hold) else $error("pads moved in standby");
  property p_off; modeState == 3'h3 |-> !aonPowered && retentionLevel == 2'h0; endproperty
  a_off: assert property (p_off) else $error("shutdown left power on");
  property p_wdog; watchdogRun |-> modeState < 3'h2; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog runs unclocked");
  property p_rpin; $fell(resetPin_n) |-> ##[1:8] sysReset; endproperty
  a_rpin: assert property (p_rpin) else $error("reset pin ignored");
endmodule // pmc_power_mode_controller_props

bind pmc_power_mode_controller pmc_power_mode_controller_props #(.PIN_W(PIN_W)) uProps (
  .clk, .rst, .irqAny, .resetPin_n, .padOut, .cpuClkEn, .memClkEn, .fastClkOn, .slowClkOn,
  .aonPowered, .corePowered, .retentionLevel, .watchdogRun, .sysReset, .modeState
);
`default_nettype wire

/* bench/pmc_power_mode_controller_tb.sv */
// self-checking bench for the power mode controller
`timescale 1ns/100ps
`default_nettype none
`include "pmc_map.vh"
module pmc_power_mode_controller_tb;
  logic       clk = 1'b0, rst = 1'b1, modeReqValid = 1'b0, irqAny = 1'b0, rtcEvent = 1'b0;
  logic       pinEdgeWake = 1'b0, monitorEvent = 1'b0, resetPin_n = 1'b1;
  logic [1:0] modeReqCode = 2'h0, retentionLevel, resetCause;
  logic [7:0] padIn = 8'h5a, padOut, periphClkEn, periphEn = 8'h3c;
  logic       fastSel = 1'b1, slowSel = 1'b0;
  logic [2:0] modeState;
  logic       cpuClkEn, memClkEn, fastClkOn, fastXtalEn, fastRcEn, slowClkOn, slowXtalEn, slowRcEn;
  logic       aonPowered, corePowered, cpuResume, sysReset, watchdogRun;
  int         nFail = 0, samplesChecked = 0, cycles = 0;
  pmc_power_mode_controller dut (.clk, .rst, .modeReqValid, .modeReqCode, .periphEnable(periphEn),
    .fastClkSelXtal(fastSel), .slowClkSelXtal(slowSel), .shutdownWakeMask(8'h01), .watchdogEnable(1'b1),
    .irqAny, .rtcEvent, .pinEdgeWake, .monitorEvent, .resetPin_n, .padIn, .padOut, .cpuClkEn,
    .memClkEn, .periphClkEn, .fastClkOn, .fastXtalEn, .fastRcEn, .slowClkOn, .slowXtalEn, .slowRcEn,
    .aonPowered, .corePowered, .retentionLevel, .cpuResume, .sysReset, .watchdogRun, .modeState,
    .resetCause);
  always #5 clk = ~clk;
  // a hang must still reach the verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      $display("Error at %0t: cycles %h limit %h", $time, cycles, 5000);
      finishTest();
    end
  end
  task automatic finishTest;
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [1:0] code);
    @(negedge clk);
    modeReqValid = 1'b1;
    modeReqCode = code;
    @(negedge clk);
    modeReqValid = 1'b0;
  endtask
  task automatic waitMode(input logic [2:0] m);
    for (int i = 0; i < 40 && modeState !== m; i++) @(negedge clk);
    check(8'(modeState), 8'(m));
  endtask
  task automatic tIdle;
    req(`PMC_REQ_NONE);
    repeat (6) @(negedge clk);
    check(8'(modeState), 8'h00);
    req(`PMC_REQ_IDLE);
    waitMode(`PMC_MODE_IDLE);
    check(8'({cpuClkEn, memClkEn, fastClkOn, fastXtalEn, fastRcEn}), 8'h06);
    check(periphClkEn, 8'h3c);
    req(`PMC_REQ_STANDBY);
    repeat (6) @(negedge clk);
    check(8'(modeState), 8'h01);
    irqAny = 1'b1;
    waitMode(`PMC_MODE_ACTIVE);
    irqAny = 1'b0;
  endtask
  // each pass wakes standby through a different source
  task automatic tStandby(input int src);
    req(`PMC_REQ_STANDBY);
    waitMode(`PMC_MODE_STANDBY);
    check(8'({fastClkOn, slowClkOn, slowRcEn, corePowered, aonPowered}), 8'h0d);
    check(8'({retentionLevel, watchdogRun}), 8'h02);
    check(periphClkEn, 8'h00);
    padIn = 8'ha5;
    irqAny = 1'b1;
    repeat (10) @(negedge clk);
    check(8'(modeState), 8'h02);
    check(padOut, 8'h5a);
    irqAny = 1'b0;
    {monitorEvent, pinEdgeWake, rtcEvent} = 3'(1 << src);
    waitMode(`PMC_MODE_ACTIVE);
    check(8'({cpuResume, sysReset, resetCause, retentionLevel}), 8'h22);
    {monitorEvent, pinEdgeWake, rtcEvent} = 3'h0;
    padIn = 8'h5a;
    repeat (6) @(negedge clk);
  endtask
  task automatic tShutdown;
    req(`PMC_REQ_SHUTDOWN);
    waitMode(`PMC_MODE_SHUTDOWN);
    check(8'({aonPowered, corePowered, slowClkOn, fastClkOn, retentionLevel}), 8'h00);
    padIn = 8'ha4;
    repeat (10) @(negedge clk);
    check(8'(modeState), 8'h03);
    check(padOut, 8'h5a);
    padIn = 8'ha5;
    waitMode(`PMC_MODE_RESET);
    waitMode(`PMC_MODE_ACTIVE);
    check(8'(resetCause), 8'(`PMC_CAUSE_WAKE));
    padIn = 8'h5a;
  endtask
  task automatic tResetPin;
    req(`PMC_REQ_STANDBY);
    waitMode(`PMC_MODE_STANDBY);
    resetPin_n = 1'b0;
    waitMode(`PMC_MODE_RESET);
    check(8'(sysReset), 8'h01);
    repeat (3) @(negedge clk);
    resetPin_n = 1'b1;
    waitMode(`PMC_MODE_ACTIVE);
    check(8'(resetCause), 8'(`PMC_CAUSE_PIN));
  endtask
  // power-on reset: held state, then boot into active
  task automatic tBoot;
    repeat (20) @(negedge clk);
    check(8'({sysReset, modeState, resetCause}), 8'h30);
    rst = 1'b0;
    waitMode(`PMC_MODE_ACTIVE);
    @(negedge clk);
    check(8'({cpuClkEn, memClkEn, watchdogRun}), 8'h07);
    check(periphClkEn, 8'h3c);
  endtask
  // clock sources and peripheral gates follow their selects while running
  task automatic tClkSel;
    fastSel = 1'b0;
    slowSel = 1'b1;
    periphEn = 8'hc3;
    repeat (2) @(negedge clk);
    check(8'({fastClkOn, fastXtalEn, fastRcEn, slowClkOn, slowXtalEn, slowRcEn}), 8'h2e);
    check(periphClkEn, 8'hc3);
    fastSel = 1'b1;
    slowSel = 1'b0;
    periphEn = 8'h3c;
    repeat (2) @(negedge clk);
  endtask
  initial begin
    tBoot();
    tClkSel();
    tIdle();
    for (int s = 0; s < 3; s++) tStandby(s);
    tShutdown();
    tResetPin();
    finishTest();
  end
endmodule // pmc_power_mode_controller_tb
`default_nettype wire

/* rtl/pmc_map.vh */
// constants for the power mode controller
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
`define PMC_MODE_ACTIVE   3'h0
`define PMC_MODE_IDLE     3'h1
`define PMC_MODE_STANDBY  3'h2
`define PMC_MODE_SHUTDOWN 3'h3
`define PMC_MODE_RESET    3'h4
`define PMC_REQ_NONE      2'h0
`define PMC_REQ_IDLE      2'h1
`define PMC_REQ_STANDBY   2'h2
`define PMC_REQ_SHUTDOWN  2'h3
`define PMC_CAUSE_POR     2'h0
`define PMC_CAUSE_PIN     2'h1
`define PMC_CAUSE_WAKE    2'h2
`define PMC_HOLD_CYCLES   4'h4
`define PMC_RET_NONE      2'h0
`define PMC_RET_PARTIAL   2'h1
`define PMC_RET_FULL      2'h2
`define PMC_WAKE_SYNC_INIT 5'h10
`endif

/* rtl/pmc_pin_latch.v */
// io pin latch that holds pad values across low-power modes
`timescale 1ns/100ps
`default_nettype none
module pmc_pin_latch #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // control
  input  wire             holdEn,
  input  wire             clearEn,
  // data
  input  wire [WIDTH-1:0] padIn,
  output reg  [WIDTH-1:0] padOut
);
  reg [WIDTH-1:0] latch_r;

  // latch the last value before hold rises, clearEn releases it to reset value
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      latch_r <= {WIDTH{1'b0}};
      padOut  <= {WIDTH{1'b0}};
    end else begin
      if (!holdEn)
        latch_r <= padIn;
      if (clearEn && !holdEn)
        latch_r <= {WIDTH{1'b0}};
      padOut <= holdEn ? latch_r : padIn;
    end
  end
endmodule // pmc_pin_latch
`default_nettype wire

/* rtl/pmc_power_mode_controller.v */
// power mode sequencer: mode state, clock gates, retention, wake and reset cause
`timescale 1ns/100ps
`default_nettype none
`include "pmc_map.vh"
module pmc_power_mode_controller #(
  parameter PERIPH_W = 8,
  parameter PIN_W    = 8
) (
  // clock and reset
  input  wire                clk,
  input  wire                rst,
  // software request, one-cycle pulse with mode code
  input  wire                modeReqValid,
  input  wire [1:0]          modeReqCode,
  // configuration from cpu side
  input  wire [PERIPH_W-1:0] periphEnable,
  input  wire                fastClkSelXtal,
  input  wire                slowClkSelXtal,
  input  wire [PIN_W-1:0]    shutdownWakeMask,
  input  wire                watchdogEnable,
  // wake sources, asynchronous to clk
  input  wire                irqAny,
  input  wire                rtcEvent,
  input  wire                pinEdgeWake,
  input  wire                monitorEvent,
  input  wire                resetPin_n,
  // io pads
  input  wire [PIN_W-1:0]    padIn,
  output wire [PIN_W-1:0]    padOut,
  // clock gates and oscillator enables
  output reg                 cpuClkEn,
  output reg                 memClkEn,
  output reg  [PERIPH_W-1:0] periphClkEn,
  output reg                 fastClkOn,
  output reg                 fastXtalEn,
  output reg                 fastRcEn,
  output reg                 slowClkOn,
  output reg                 slowXtalEn,
  output reg                 slowRcEn,
  // power and retention
  output reg                 aonPowered,
  output reg                 corePowered,
  output reg  [1:0]          retentionLevel,
  output reg                 cpuResume,
  output reg                 sysReset,
  output reg                 watchdogRun,
  // status
  output reg  [2:0]          modeState,
  output reg  [1:0]          resetCause
);
  // retention depth codes driven on retentionLevel
  localparam RET_NONE    = `PMC_RET_NONE;
  localparam RET_PARTIAL = `PMC_RET_PARTIAL;
  localparam RET_FULL    = `PMC_RET_FULL;

  // fast clock domain and cpu-side core are up only in active and idle
  function clockedMode;
    input [2:0] m;
    begin
      clockedMode = (m == `PMC_MODE_ACTIVE) || (m == `PMC_MODE_IDLE);
    end
  endfunction

  // low speed clock survives standby but not shutdown or a held reset
  function slowClockMode;
    input [2:0] m;
    begin
      slowClockMode = (m != `PMC_MODE_SHUTDOWN) && (m != `PMC_MODE_RESET);
    end
  endfunction

  // pads are frozen in standby and shutdown, but not in reset although the core domain is unpowered there
  function pinHoldMode;
    input [2:0] m;
    begin
      pinHoldMode = (m == `PMC_MODE_STANDBY) || (m == `PMC_MODE_SHUTDOWN);
    end
  endfunction

  // register retention depth per mode
  function [1:0] retentionOf;
    input [2:0] m;
    begin
      case (m)
        `PMC_MODE_ACTIVE:  retentionOf = RET_FULL;
        `PMC_MODE_IDLE:    retentionOf = RET_FULL;
        `PMC_MODE_STANDBY: retentionOf = RET_PARTIAL;
        default:           retentionOf = RET_NONE;
      endcase
    end
  endfunction

  // two-stage synchronisers; stage one read only by stage two
  reg [4:0]       wakeS1_r;
  reg [4:0]       wakeS2_r;
  // pad samples also feed the shutdown change detector
  reg [PIN_W-1:0] padS1_r;
  reg [PIN_W-1:0] padS2_r;
  reg [PIN_W-1:0] padRef_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // reset pin idles high, so its stages start released
      wakeS1_r <= `PMC_WAKE_SYNC_INIT;
      wakeS2_r <= `PMC_WAKE_SYNC_INIT;
      padS1_r  <= {PIN_W{1'b0}};
      padS2_r  <= {PIN_W{1'b0}};
    end else begin
      wakeS1_r <= {resetPin_n, monitorEvent, pinEdgeWake, rtcEvent, irqAny};
      wakeS2_r <= wakeS1_r;
      padS1_r  <= padIn;
      padS2_r  <= padS1_r;
    end
  end

  // synchronised wake levels; reset pin turned active high here
  wire irqS    = wakeS2_r[0];
  wire rtcS    = wakeS2_r[1];
  wire pinS    = wakeS2_r[2];
  wire monS    = wakeS2_r[3];
  wire rstPinS = ~wakeS2_r[4];

  // any masked shutdown pin differing from its reference value
  wire shutPinChange = |((padS2_r ^ padRef_r) & shutdownWakeMask);

  // sequencer state; modeState shows mode_r one clock later
  reg [2:0] mode_r;
  reg [2:0] mode_nxt;
  reg [1:0] cause_r;
  reg [1:0] cause_nxt;
  reg [3:0] hold_r;
  reg [3:0] hold_nxt;
  reg       resume_r;
  reg       resume_nxt;
  reg       wdtEn_r;

  // mode sequencer; reset pin has priority in every mode
  always @* begin
    mode_nxt   = mode_r;
    cause_nxt  = cause_r;
    hold_nxt   = hold_r;
    resume_nxt = 1'b0;
    if (rstPinS) begin
      mode_nxt  = `PMC_MODE_RESET;
      cause_nxt = `PMC_CAUSE_PIN;
      // the hold count restarts for as long as the pin stays low
      hold_nxt  = `PMC_HOLD_CYCLES;
    end else begin
      case (mode_r)
        `PMC_MODE_ACTIVE: begin
          // requests count only while running
          if (modeReqValid) begin
            case (modeReqCode)
              `PMC_REQ_IDLE:     mode_nxt = `PMC_MODE_IDLE;
              `PMC_REQ_STANDBY:  mode_nxt = `PMC_MODE_STANDBY;
              `PMC_REQ_SHUTDOWN: mode_nxt = `PMC_MODE_SHUTDOWN;
              default:           mode_nxt = `PMC_MODE_ACTIVE;
            endcase
          end
        end
        `PMC_MODE_IDLE: begin
          // the cpu clock was only stopped, so no resume pulse is needed
          if (irqS)
            mode_nxt = `PMC_MODE_ACTIVE;
        end
        `PMC_MODE_STANDBY: begin
          // interrupts alone do not wake standby
          if (pinS || rtcS || monS) begin
            mode_nxt   = `PMC_MODE_ACTIVE;
            resume_nxt = 1'b1;
          end
        end
        `PMC_MODE_SHUTDOWN: begin
          // a masked pad that moved since entry restarts the device as a reset
          if (shutPinChange) begin
            mode_nxt  = `PMC_MODE_RESET;
            cause_nxt = `PMC_CAUSE_WAKE;
            hold_nxt  = `PMC_HOLD_CYCLES;
          end
        end
        `PMC_MODE_RESET: begin
          // a reset ends in a fresh boot, never a resume
          if (hold_r != 4'h0)
            hold_nxt = hold_r - 4'h1;
          else
            mode_nxt = `PMC_MODE_ACTIVE;
        end
        // an illegal code recovers through a clean boot
        default: mode_nxt = `PMC_MODE_RESET;
      endcase
    end
  end

  // mode state registers; a power-on reset boots through the hold count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r   <= `PMC_MODE_RESET;
      cause_r  <= `PMC_CAUSE_POR;
      hold_r   <= `PMC_HOLD_CYCLES;
      resume_r <= 1'b0;
    end else begin
      mode_r   <= mode_nxt;
      cause_r  <= cause_nxt;
      hold_r   <= hold_nxt;
      resume_r <= resume_nxt;
    end
  end

  // reference pad state taken on shutdown entry for change detection
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      padRef_r <= {PIN_W{1'b0}};
    end else if (mode_r != `PMC_MODE_SHUTDOWN) begin
      padRef_r <= padS2_r;
    end
  end

  // watchdog enable is sticky: software cannot clear it, only reset or shutdown
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wdtEn_r <= 1'b0;
    end else if (mode_r == `PMC_MODE_RESET || mode_r == `PMC_MODE_SHUTDOWN) begin
      wdtEn_r <= 1'b0;
    end else if (watchdogEnable) begin
      wdtEn_r <= 1'b1;
    end
  end

  // pads freeze in standby and shutdown; reset releases the stale hold value
  wire holdPins  = pinHoldMode(mode_r);
  wire clearPins = (mode_r == `PMC_MODE_RESET);

  // pads pass through the sync pipeline, so padOut lags padIn by three clocks
  pmc_pin_latch #(
    .WIDTH (PIN_W)
  ) uPinLatch (
    .clk     (clk),
    .rst     (rst),
    .holdEn  (holdPins),
    .clearEn (clearPins),
    .padIn   (padS2_r),
    .padOut  (padOut)
  );

  // next values of the registered outputs, decoded from the settled mode except cpuResume and resetCause
  reg                cpuClkEn_nxt;
  reg                memClkEn_nxt;
  reg [PERIPH_W-1:0] periphClkEn_nxt;
  reg                fastClkOn_nxt;
  reg                fastXtalEn_nxt;
  reg                fastRcEn_nxt;
  reg                slowClkOn_nxt;
  reg                slowXtalEn_nxt;
  reg                slowRcEn_nxt;
  reg                aonPowered_nxt;
  reg                corePowered_nxt;
  reg [1:0]          retentionLevel_nxt;
  reg                cpuResume_nxt;
  reg                sysReset_nxt;
  reg                watchdogRun_nxt;
  reg [2:0]          modeState_nxt;
  reg [1:0]          resetCause_nxt;

  always @* begin
    cpuClkEn_nxt       = (mode_r == `PMC_MODE_ACTIVE);
    memClkEn_nxt       = (mode_r == `PMC_MODE_ACTIVE);
    periphClkEn_nxt    = clockedMode(mode_r) ? periphEnable : {PERIPH_W{1'b0}};
    fastClkOn_nxt      = clockedMode(mode_r);
    fastXtalEn_nxt     = clockedMode(mode_r) && fastClkSelXtal;
    fastRcEn_nxt       = clockedMode(mode_r) && !fastClkSelXtal;
    slowClkOn_nxt      = slowClockMode(mode_r);
    slowXtalEn_nxt     = slowClockMode(mode_r) && slowClkSelXtal;
    slowRcEn_nxt       = slowClockMode(mode_r) && !slowClkSelXtal;
    aonPowered_nxt     = (mode_r != `PMC_MODE_SHUTDOWN);
    corePowered_nxt    = clockedMode(mode_r);
    retentionLevel_nxt = retentionOf(mode_r);
    cpuResume_nxt      = resume_r;
    sysReset_nxt       = (mode_r == `PMC_MODE_RESET);
    watchdogRun_nxt    = wdtEn_r && clockedMode(mode_r);
    modeState_nxt      = mode_r;
    resetCause_nxt     = cause_r;
  end

  // every output moves on the same edge, one clock after the mode register, except watchdogRun, which rises two clocks after it out of reset
  // registered decode of the current mode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cpuClkEn       <= 1'b0;
      memClkEn       <= 1'b0;
      periphClkEn    <= {PERIPH_W{1'b0}};
      fastClkOn      <= 1'b0;
      fastXtalEn     <= 1'b0;
      fastRcEn       <= 1'b0;
      slowClkOn      <= 1'b0;
      slowXtalEn     <= 1'b0;
      slowRcEn       <= 1'b0;
      aonPowered     <= 1'b0;
      corePowered    <= 1'b0;
      retentionLevel <= RET_NONE;
      cpuResume      <= 1'b0;
      sysReset       <= 1'b1;
      watchdogRun    <= 1'b0;
      modeState      <= `PMC_MODE_RESET;
      resetCause     <= `PMC_CAUSE_POR;
    end else begin
      cpuClkEn       <= cpuClkEn_nxt;
      memClkEn       <= memClkEn_nxt;
      periphClkEn    <= periphClkEn_nxt;
      fastClkOn      <= fastClkOn_nxt;
      fastXtalEn     <= fastXtalEn_nxt;
      fastRcEn       <= fastRcEn_nxt;
      slowClkOn      <= slowClkOn_nxt;
      slowXtalEn     <= slowXtalEn_nxt;
      slowRcEn       <= slowRcEn_nxt;
      aonPowered     <= aonPowered_nxt;
      corePowered    <= corePowered_nxt;
      retentionLevel <= retentionLevel_nxt;
      cpuResume      <= cpuResume_nxt;
      sysReset       <= sysReset_nxt;
      watchdogRun    <= watchdogRun_nxt;
      modeState      <= modeState_nxt;
      resetCause     <= resetCause_nxt;
    end
  end
endmodule // pmc_power_mode_controller
`default_nettype wire
